// [rtl/axis_cmp_regs.svh]
// register offsets, field positions and limits of the axis hold and compare block
// assumes byte addresses on an 8-bit register port, one 32-bit word per register
`ifndef AXIS_CMP_REGS_SVH
`define AXIS_CMP_REGS_SVH

`define OFF_OPERATION_MODE  8'h00
`define OFF_ENV_THREE       8'h04
`define OFF_ENV_FOUR        8'h08
`define OFF_ENV_FIVE        8'h0C
`define OFF_CMP1_VALUE      8'h10
`define OFF_CMP2_VALUE      8'h14
`define OFF_CMP3_VALUE      8'h18
`define OFF_CMP4_VALUE      8'h1C
`define OFF_CMP5_VALUE      8'h20
`define OFF_CMP5_PRE        8'h24
`define OFF_IRQ_REQUEST     8'h28
`define OFF_STATUS          8'h2C

`define OPM_CMD_STOP        11
`define ENV3_GEN_BUSY_ONLY  14
`define ENV3_GEN_HALF_CLK   15
`define ENV3_CORR_LSB       16
`define ENV3_HOLD_MECH      29
`define ENV3_HOLD_DEFL      30
`define ENV3_HOLD_GEN       31

`define CMP_SEL_LSB(n)      (8 * (n))
`define CMP_METH_LSB(n)     (8 * (n) + 2)
`define CMP_ACT_LSB(n)      ((n) == 3 ? 30 : 8 * (n) + 5)
`define CMP5_SEL_LSB        0
`define CMP5_METH_LSB       3
`define CMP5_ACT_LSB        6
`define IRQ_EN_LSB          8
`define STAT_MATCH_LSB      8
`define STAT_INDEX_BIT      13

`define DEFL_ABS_MAX        28'h0007FFF
`define REG_RESET           32'h00000000

`endif

// [rtl/axis_cmp_pkg.sv]
// types shared by the axis hold and compare block
// assumes 28-bit comparison values and sources
package axis_cmp_pkg;
	typedef logic [27:0] cmp_value_t;

	typedef enum logic [3:0] {
		meth_off        = 4'h0,
		meth_eq         = 4'h1,
		meth_eq_up      = 4'h2,
		meth_eq_down    = 4'h3,
		meth_val_gt     = 4'h4,
		meth_val_lt     = 4'h5,
		meth_soft_lim   = 4'h6,
		meth_index      = 4'h8,
		meth_index_up   = 4'h9,
		meth_index_down = 4'hA
	} method_e;

	typedef enum logic [1:0] {
		act_none   = 2'h0,
		act_stop   = 2'h1,
		act_decel  = 2'h2,
		act_reload = 2'h3
	} action_e;
endpackage : axis_cmp_pkg

// [rtl/cmp_unit.sv]
// one 28-bit comparator: source select, method decode, registered match
// assumes sources and directions come from logic on the same clock
`timescale 1ns/1ps
`default_nettype none

module cmp_unit #(
	parameter int CMP_ID = 1,
	parameter int SEL_W  = 2,
	parameter int METH_W = 3
) (
	// clock and reset
	input  wire logic                           clk,
	input  wire logic                           rst_n,
	// configuration
	input  wire logic [27:0]                    value,
	input  wire logic [SEL_W-1:0]               source_select,
	input  wire logic [METH_W-1:0]              method,
	// sources: counters 1-4, positioning counter, current speed
	input  wire logic [5:0][27:0]               sources,
	input  wire logic [5:0]                     dir_up,
	// results
	output logic                                match,
	output logic                                index_hit
);

	localparam int NUM_SRC = 6;

	logic [3:0]  meth4;
	logic [27:0] src;
	logic        up;
	logic [1:0]  result;

	// returns {match, index}; unlisted codes never match
	function automatic logic [1:0] evaluate(input logic [3:0] m, input logic [27:0] v,
		input logic [27:0] s, input logic u);
		logic eq;
		logic gt;
		logic lt;
		eq = (v == s);
		gt = ($signed(v) > $signed(s));
		lt = ($signed(v) < $signed(s));
		evaluate = 2'h0;
		case (m)
			axis_cmp_pkg::meth_eq:      evaluate = {eq, 1'b0};
			axis_cmp_pkg::meth_eq_up:   evaluate = {eq && u, 1'b0};
			axis_cmp_pkg::meth_eq_down: evaluate = {eq && !u, 1'b0};
			axis_cmp_pkg::meth_val_gt:  evaluate = {gt, 1'b0};
			axis_cmp_pkg::meth_val_lt:  evaluate = {lt, 1'b0};
			axis_cmp_pkg::meth_soft_lim: begin
				// positive limit on value < source, negative on value > source
				if (CMP_ID == 1)
					evaluate = {lt, 1'b0};
				else if (CMP_ID == 2)
					evaluate = {gt, 1'b0};
			end
			axis_cmp_pkg::meth_index:      if (CMP_ID == 4) evaluate = {eq, 1'b1};
			axis_cmp_pkg::meth_index_up:   if (CMP_ID == 4) evaluate = {eq && u, 1'b1};
			axis_cmp_pkg::meth_index_down: if (CMP_ID == 4) evaluate = {eq && !u, 1'b1};
			default:                       evaluate = 2'h0;
		endcase
	endfunction : evaluate

	assign meth4  = 4'(method);
	// select codes past the last source read as zero, never as unknown
	assign src    = (int'(source_select) < NUM_SRC) ? sources[source_select] : '0;
	assign up     = (int'(source_select) < NUM_SRC) && dir_up[source_select];
	assign result = evaluate(meth4, value, src, up);

	// re-evaluated every cycle, result one cycle later
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			match     <= 1'b0;
			index_hit <= 1'b0;
		end else begin
			match     <= result[1];
			index_hit <= result[1] && result[0];
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	a_equal_match:  assert property ((meth4 == 4'h1 && value == src) |=> match)
		else $error("equal compare missed");
	a_off_silent:   assert property ((meth4 == 4'h0) |=> !match)
		else $error("disabled comparator matched");
	a_greater_val:  assert property ((meth4 == 4'h4) |=> match == $past($signed(value) > $signed(src)))
		else $error("greater-than compare wrong");
	a_dir_filter:   assert property ((meth4 == 4'h2 && !up) |=> !match)
		else $error("count-up compare matched while counting down");

endmodule : cmp_unit

`default_nettype wire

// [rtl/axis_cmp_block.sv]
// axis counter hold/gating and five comparators with register port
// assumes counters, busy and direction come from motion logic on clk
//
// The plain strobed port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "axis_cmp_regs.svh"

module axis_cmp_block (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst_n,
	// register port
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata,
	// motion core status
	input  wire logic        timer_mode,
	input  wire logic        axis_busy_n,
	input  wire logic        correction_pulse,
	input  wire logic        axis_dir_up,
	// counter pulses in and gated counts out
	input  wire logic [3:0]  count_pulse,
	input  wire logic [3:0]  counter_up,
	output logic      [3:0]  count_enable,
	// comparison sources
	input  wire logic [27:0] command_position_counter,
	input  wire logic [27:0] mechanical_position_counter,
	input  wire logic [27:0] deflection_counter,
	input  wire logic [27:0] general_purpose_counter,
	input  wire logic [27:0] positioning_counter,
	input  wire logic [27:0] current_speed,
	// results
	output logic             positive_soft_limit,
	output logic             negative_soft_limit,
	output logic             index_pulse_out,
	output logic             stop_now,
	output logic             stop_decel,
	output logic             load_pre_data,
	output logic             int_n
);

	logic [31:0]                    operation_mode;
	logic [31:0]                    environment_three;
	logic [31:0]                    environment_four;
	logic [31:0]                    environment_five;
	logic [31:0]                    irq_request;
	axis_cmp_pkg::cmp_value_t [4:0] cmp_value;
	axis_cmp_pkg::cmp_value_t       cmp5_pre;
	logic [4:0]                     match;
	logic [4:0]                     match_q;
	logic [4:0]                     match_rise;
	logic [3:0]                     index_hit;
	logic                           index_q;
	logic                           half_tick;
	logic [3:0]                     allow;
	logic [3:0]                     pulse_in;
	logic [27:0]                    defl_abs;
	logic [27:0]                    defl_mag;
	logic [5:0][27:0]               sources;
	logic [5:0]                     dir_up;
	logic [4:0][1:0]                action;
	logic [4:0]                     cmp1_irq_enable;
	logic                           neg_limit_armed;

	// register writes
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			operation_mode    <= `REG_RESET;
			environment_three <= `REG_RESET;
			environment_four  <= `REG_RESET;
			environment_five  <= `REG_RESET;
			irq_request       <= `REG_RESET;
			cmp5_pre          <= 28'h0000000;
		end else if (reg_wr) begin
			case (reg_addr)
				`OFF_OPERATION_MODE: operation_mode    <= reg_wdata;
				`OFF_ENV_THREE:      environment_three <= reg_wdata;
				`OFF_ENV_FOUR:       environment_four  <= reg_wdata;
				`OFF_ENV_FIVE:       environment_five  <= reg_wdata;
				`OFF_IRQ_REQUEST:    irq_request       <= reg_wdata;
				`OFF_CMP5_PRE:       cmp5_pre          <= reg_wdata[27:0];
				default: ;
			endcase
		end
	end

	// comparison values; comparator 5 reloads from its pre-register on a match
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cmp_value <= '0;
		end else begin
			if (reg_wr) begin
				case (reg_addr)
					`OFF_CMP1_VALUE: cmp_value[0] <= reg_wdata[27:0];
					`OFF_CMP2_VALUE: cmp_value[1] <= reg_wdata[27:0];
					`OFF_CMP3_VALUE: cmp_value[2] <= reg_wdata[27:0];
					`OFF_CMP4_VALUE: cmp_value[3] <= reg_wdata[27:0];
					`OFF_CMP5_VALUE: cmp_value[4] <= reg_wdata[27:0];
					default: ;
				endcase
			end
			if (match_rise[4])
				cmp_value[4] <= cmp5_pre;
		end
	end

	// read data, one cycle after the strobe; unmapped reads as zero
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= 32'h00000000;
		end else if (reg_rd) begin
			case (reg_addr)
				`OFF_OPERATION_MODE: reg_rdata <= operation_mode;
				`OFF_ENV_THREE:      reg_rdata <= environment_three;
				`OFF_ENV_FOUR:       reg_rdata <= environment_four;
				`OFF_ENV_FIVE:       reg_rdata <= environment_five;
				`OFF_IRQ_REQUEST:    reg_rdata <= irq_request;
				`OFF_CMP1_VALUE:     reg_rdata <= {4'h0, cmp_value[0]};
				`OFF_CMP2_VALUE:     reg_rdata <= {4'h0, cmp_value[1]};
				`OFF_CMP3_VALUE:     reg_rdata <= {4'h0, cmp_value[2]};
				`OFF_CMP4_VALUE:     reg_rdata <= {4'h0, cmp_value[3]};
				`OFF_CMP5_VALUE:     reg_rdata <= {4'h0, cmp_value[4]};
				`OFF_CMP5_PRE:       reg_rdata <= {4'h0, cmp5_pre};
				`OFF_STATUS: begin
					reg_rdata <= 32'h00000000;
					reg_rdata[`STAT_MATCH_LSB +: 5] <= match;
					reg_rdata[`STAT_INDEX_BIT]      <= index_q;
					reg_rdata[3:0]                  <= count_enable;
				end
				default:             reg_rdata <= 32'h00000000;
			endcase
		end
	end

	// half reference clock tick for the general counter
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			half_tick <= 1'b0;
		else
			half_tick <= !half_tick;
	end

	// hold conditions per counter
	assign allow[0] = !(timer_mode && operation_mode[`OPM_CMD_STOP]);
	assign allow[1] = !environment_three[`ENV3_HOLD_MECH];
	assign allow[2] = !environment_three[`ENV3_HOLD_DEFL];
	assign allow[3] = !environment_three[`ENV3_HOLD_GEN] &&
		(!environment_three[`ENV3_GEN_BUSY_ONLY] || !axis_busy_n);

	assign pulse_in[2:0] = count_pulse[2:0];
	assign pulse_in[3]   = environment_three[`ENV3_GEN_HALF_CLK] ? half_tick
	                                                             : count_pulse[3];

	// gated count strobes, correction pulses pass only where enabled
	generate
		for (genvar i = 0; i < 4; i++) begin : g_gate
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n)
					count_enable[i] <= 1'b0;
				else
					count_enable[i] <= pulse_in[i] && allow[i] &&
						(!correction_pulse || environment_three[`ENV3_CORR_LSB + i]);
			end
		end
	endgenerate

	// deflection magnitude, clamped to the 15-bit range
	assign defl_mag = deflection_counter[27] ? 28'(-deflection_counter) : deflection_counter;
	assign defl_abs = (defl_mag > `DEFL_ABS_MAX) ? `DEFL_ABS_MAX : defl_mag;

	assign sources[0] = command_position_counter;
	assign sources[1] = mechanical_position_counter;
	assign sources[2] = defl_abs;
	assign sources[3] = general_purpose_counter;
	assign sources[4] = positioning_counter;
	assign sources[5] = current_speed;
	assign dir_up     = {axis_dir_up, axis_dir_up, counter_up};

	// comparators 1 to 4 in environment four, one byte each
	generate
		for (genvar n = 0; n < 3; n++) begin : g_cmp
			cmp_unit #(
				.CMP_ID (n + 1),
				.SEL_W  (2),
				.METH_W (3)
			) u_cmp (
				.clk           (clk),
				.rst_n         (rst_n),
				.value         (cmp_value[n]),
				.source_select (environment_four[`CMP_SEL_LSB(n) +: 2]),
				.method        (environment_four[`CMP_METH_LSB(n) +: 3]),
				.sources       (sources),
				.dir_up        (dir_up),
				.match         (match[n]),
				.index_hit     (index_hit[n])
			);
		end
	endgenerate

	cmp_unit #(
		.CMP_ID (4),
		.SEL_W  (2),
		.METH_W (4)
	) u_cmp4 (
		.clk           (clk),
		.rst_n         (rst_n),
		.value         (cmp_value[3]),
		.source_select (environment_four[`CMP_SEL_LSB(3) +: 2]),
		.method        (environment_four[`CMP_METH_LSB(3) +: 4]),
		.sources       (sources),
		.dir_up        (dir_up),
		.match         (match[3]),
		.index_hit     (index_hit[3])
	);

	cmp_unit #(
		.CMP_ID (5),
		.SEL_W  (3),
		.METH_W (3)
	) u_cmp5 (
		.clk           (clk),
		.rst_n         (rst_n),
		.value         (cmp_value[4]),
		.source_select (environment_five[`CMP5_SEL_LSB +: 3]),
		.method        (environment_five[`CMP5_METH_LSB +: 3]),
		.sources       (sources),
		.dir_up        (dir_up),
		.match         (match[4]),
		.index_hit     ()
	);

	// action field per comparator
	generate
		for (genvar n = 0; n < 4; n++) begin : g_act
			assign action[n] = environment_four[`CMP_ACT_LSB(n) +: 2];
		end
	endgenerate
	assign action[4]       = environment_five[`CMP5_ACT_LSB +: 2];
	assign match_rise      = match & ~match_q;
	assign cmp1_irq_enable = irq_request[`IRQ_EN_LSB +: 5];

	// match edges, actions and index pulse
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			match_q         <= 5'h00;
			index_q         <= 1'b0;
			index_pulse_out <= 1'b0;
			stop_now        <= 1'b0;
			stop_decel      <= 1'b0;
			load_pre_data   <= 1'b0;
		end else begin
			match_q         <= match;
			index_q         <= index_hit[3];
			index_pulse_out <= index_hit[3] && !index_q;
			stop_now        <= 1'b0;
			stop_decel      <= 1'b0;
			load_pre_data   <= 1'b0;
			for (int k = 0; k < 5; k++) begin
				if (match_rise[k]) begin
					case (action[k])
						axis_cmp_pkg::act_stop:   stop_now      <= 1'b1;
						axis_cmp_pkg::act_decel:  stop_decel    <= 1'b1;
						axis_cmp_pkg::act_reload: load_pre_data <= 1'b1;
						default: ;
					endcase
				end
			end
		end
	end

	// software limits and interrupt level
	assign positive_soft_limit = match[0] &&
		(environment_four[`CMP_METH_LSB(0) +: 3] == 3'h6);
	assign negative_soft_limit = match[1] &&
		(environment_four[`CMP_METH_LSB(1) +: 3] == 3'h6);
	assign int_n = !(|(match & cmp1_irq_enable));

	// comparator 2 armed as negative limit on the command counter, for the checks
	assign neg_limit_armed = !reg_wr &&
		(environment_four[`CMP_METH_LSB(1) +: 3] == 3'h6) &&
		(environment_four[`CMP_SEL_LSB(1) +: 2] == 2'h0) &&
		($signed(cmp_value[1]) > $signed(command_position_counter));

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	a_cmd_hold:     assert property ((timer_mode && operation_mode[11]) |=> !count_enable[0])
		else $error("command counter counted while held");
	a_mech_hold:    assert property (environment_three[29] |=> !count_enable[1])
		else $error("mechanical counter counted while held");
	a_corr_gate:    assert property ((correction_pulse && !environment_three[18]) |=> !count_enable[2])
		else $error("deflection counter took a correction pulse");
	a_gen_busy:     assert property ((environment_three[14] && axis_busy_n) |=> !count_enable[3])
		else $error("general counter counted while idle");
	a_half_rate:    assert property ((environment_three[15] && count_enable[3] &&
		$past(environment_three[15])) |=> !count_enable[3])
		else $error("general counter faster than half clock");
	a_defl_abs:     assert property (defl_abs <= 28'h0007FFF)
		else $error("deflection magnitude out of range");
	a_stop_action:  assert property ((match_rise[1] && action[1] == 2'h1) |=> stop_now)
		else $error("immediate stop not raised");
	a_pre_load:     assert property ((match_rise[4] && !reg_wr) |=> cmp_value[4] == $past(cmp5_pre))
		else $error("pre-register not transferred");
	a_int_cmp5:     assert property ((match[4] && irq_request[12]) |-> !int_n)
		else $error("comparator five interrupt missing");
	a_int_masked:   assert property ((irq_request[12:8] == 5'h00) |-> int_n)
		else $error("interrupt raised while disabled");
	a_mech_free:    assert property ((!environment_three[29] && !correction_pulse &&
		count_pulse[1]) |=> count_enable[1])
		else $error("mechanical counter missed a pulse");
	a_decel_action: assert property (match_rise[0] && action[0] == 2'h2 |=> stop_decel)
		else $error("decelerating stop not raised");
	a_reload_act:   assert property (match_rise[0] && action[0] == 2'h3 |=>
		load_pre_data)
		else $error("reload of operating data not raised");
	a_neg_limit:    assert property (neg_limit_armed |=> negative_soft_limit)
		else $error("negative software limit missed");

	c_cmp5_match:   cover property ($rose(match[4]));
	c_soft_limit:   cover property (positive_soft_limit ##1 stop_now);
	c_index:        cover property (index_pulse_out);
	c_decel:        cover property (stop_decel);
	c_reload:       cover property (load_pre_data);

endmodule : axis_cmp_block

`default_nettype wire

// [tb/motion_model.sv]
// far-side motion core model: counters 1-4, positioning, speed, direction
// assumes the bench presets the counters and requests the raw count pulses
`timescale 1ns/1ps
`default_nettype none

module motion_model (
	// clock and reset
	input  wire logic             clk,
	input  wire logic             rst_n,
	// bench control
	input  wire logic             load,
	input  wire logic [5:0][27:0] preset,
	input  wire logic [3:0]       pulse_req,
	input  wire logic             dir,
	// toward the block
	input  wire logic [3:0]       count_enable,
	output logic      [3:0]       count_pulse,
	output logic      [3:0]       counter_up,
	output logic                  axis_dir_up,
	output logic      [5:0][27:0] src
);
	assign count_pulse = pulse_req;
	assign counter_up  = {4{dir}};
	assign axis_dir_up = dir;

	// counters move only on the block's gated strobe
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			src <= '0;
		end else if (load) begin
			src <= preset;
		end else begin
			for (int i = 0; i < 4; i++) begin
				if (count_enable[i]) begin
					src[i] <= dir ? src[i] + 28'h1 : src[i] - 28'h1;
				end
			end
		end
	end
endmodule : motion_model

`default_nettype wire

// [tb/axis_cmp_block_tb_top.sv]
// bench for the axis hold and compare block beside a motion core model
// assumes register offsets from the shared header and a single clock
`timescale 1ns/1ps
`default_nettype none
`include "axis_cmp_regs.svh"

module axis_cmp_block_tb_top;
	typedef struct {
		int          n;
		logic [2:0]  sel;
		logic [3:0]  meth;
		logic [27:0] val;
		logic [27:0] s;
		logic        d;
		logic        m;
	} row_s;

	logic             clk;
	logic             rst_n;
	logic [7:0]       addr;
	logic [31:0]      wdata;
	logic             wr_s;
	logic             rd_s;
	logic [31:0]      rdata;
	logic             tmode;
	logic             busy_n;
	logic             corr;
	logic             load;
	logic [5:0][27:0] pre;
	logic [3:0]       req;
	logic             dir;
	logic [3:0]       pulse_w;
	logic [3:0]       up_w;
	logic [3:0]       en_w;
	logic             dir_w;
	logic [5:0][27:0] src;
	logic             psl;
	logic             nsl;
	logic             index_w;
	logic             stop_now;
	logic             decel;
	logic             reload;
	logic             int_n;
	int               fails;
	int               num_checks;
	int               cyc;

	row_s rows [14] = '{
		'{0, 3'h0, 4'h1, 28'h64, 28'h64, 1'b1, 1'b1},
		'{1, 3'h1, 4'h2, 28'h7, 28'h7, 1'b0, 1'b0},
		'{1, 3'h1, 4'h2, 28'h7, 28'h7, 1'b1, 1'b1},
		'{1, 3'h3, 4'h1, 28'h0123456, 28'h1, 1'b1, 1'b0},
		'{2, 3'h2, 4'h3, 28'h5, 28'hFFFFFFB, 1'b0, 1'b1},
		'{2, 3'h2, 4'h1, 28'h7FFF, 28'hC350, 1'b1, 1'b1},
		'{3, 3'h3, 4'h4, 28'hA, 28'h9, 1'b1, 1'b1},
		'{3, 3'h3, 4'h5, 28'hA, 28'h9, 1'b1, 1'b0},
		'{3, 3'h3, 4'h0, 28'h9, 28'h9, 1'b1, 1'b0},
		'{4, 3'h4, 4'h1, 28'h7, 28'h7, 1'b1, 1'b1},
		'{4, 3'h5, 4'h5, 28'h3, 28'h4, 1'b1, 1'b1},
		'{4, 3'h0, 4'h7, 28'h9, 28'h9, 1'b1, 1'b0},
		'{0, 3'h0, 4'h4, 28'h5, 28'hFFFFFFE, 1'b1, 1'b1},
		'{2, 3'h2, 4'h5, 28'h3, 28'h4, 1'b1, 1'b1}
	};

	motion_model partner (
		.clk(clk), .rst_n(rst_n), .load(load), .preset(pre), .pulse_req(req),
		.dir(dir), .count_enable(en_w), .count_pulse(pulse_w), .counter_up(up_w),
		.axis_dir_up(dir_w), .src(src)
	);

	axis_cmp_block uut (
		.clk(clk), .rst_n(rst_n), .reg_addr(addr), .reg_wdata(wdata),
		.reg_wr(wr_s), .reg_rd(rd_s), .reg_rdata(rdata), .timer_mode(tmode),
		.axis_busy_n(busy_n), .correction_pulse(corr), .axis_dir_up(dir_w),
		.count_pulse(pulse_w), .counter_up(up_w), .count_enable(en_w),
		.command_position_counter(src[0]), .mechanical_position_counter(src[1]),
		.deflection_counter(src[2]), .general_purpose_counter(src[3]),
		.positioning_counter(src[4]), .current_speed(src[5]),
		.positive_soft_limit(psl), .negative_soft_limit(nsl), .index_pulse_out(index_w),
		.stop_now(stop_now), .stop_decel(decel), .load_pre_data(reload), .int_n(int_n)
	);

	task automatic give_verdict;
		if (fails == 0 && num_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : give_verdict

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			fails++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		addr  <= a;
		wdata <= v;
		wr_s  <= 1'b1;
		@(posedge clk);
		wr_s  <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge clk);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge clk);
		rd_s <= 1'b0;
		#1 v = rdata;
	endtask : rd

	task automatic ld(input logic [5:0][27:0] p, input logic dv);
		@(posedge clk);
		pre  <= p;
		dir  <= dv;
		load <= 1'b1;
		@(posedge clk);
		load <= 1'b0;
	endtask : ld

	task automatic pulse(input logic [3:0] m, input logic [3:0] e);
		@(posedge clk);
		req <= m;
		@(posedge clk);
		req <= 4'h0;
		#1 chk("count_enable", {28'h0, e}, {28'h0, en_w});
	endtask : pulse

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			fails++;
			give_verdict();
		end
	end

	initial begin
		row_s             r;
		logic [31:0]      d;
		logic [5:0][27:0] p;
		int               k;
		int               cnt;
		int               lows;
		logic [7:0]       ra [6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h28, 8'hFC};
		logic [3:0]       im [3] = '{4'h8, 4'h9, 4'hA};
		logic             idr [3] = '{1'b1, 1'b0, 1'b0};
		logic [31:0]      ie [3] = '{32'h1, 32'h0, 32'h1};
		rst_n  = 1'b0;
		addr   = 8'h00;
		wdata  = 32'h0;
		wr_s   = 1'b0;
		rd_s   = 1'b0;
		tmode  = 1'b0;
		busy_n = 1'b1;
		corr   = 1'b0;
		load   = 1'b0;
		pre    = '0;
		req    = 4'h0;
		dir    = 1'b1;
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		for (k = 0; k < 6; k++) begin
			rd(ra[k], d);
			chk("reset value", 32'h0, d);
		end
		foreach (rows[k]) begin
			r = rows[k];
			p = {6{28'h0123456}};
			p[r.sel] = r.s;
			ld(p, r.d);
			wr(`OFF_CMP5_PRE, {4'h0, r.val});
			wr(8'(`OFF_CMP1_VALUE + 4 * r.n), {4'h0, r.val});
			if (r.n < 4) begin
				wr(`OFF_ENV_FIVE, 32'h0);
				wr(`OFF_ENV_FOUR, ({29'h0, r.sel} | {28'h0, r.meth} << 2) << (8 * r.n));
			end else begin
				wr(`OFF_ENV_FOUR, 32'h0);
				wr(`OFF_ENV_FIVE, {26'h0, r.meth[2:0], r.sel});
			end
			rd(`OFF_STATUS, d);
			chk("match", {31'h0, r.m}, {31'h0, d[8 + r.n]});
			chk("int_n masked", 32'h1, {31'h0, int_n});
		end
		wr(`OFF_OPERATION_MODE, 32'h800);
		@(posedge clk) tmode <= 1'b1;
		pulse(4'hF, 4'hE);
		@(posedge clk) tmode <= 1'b0;
		pulse(4'hF, 4'hF);
		wr(`OFF_ENV_THREE, 32'hE0000000);
		pulse(4'hF, 4'h1);
		wr(`OFF_ENV_THREE, 32'h00010000);
		@(posedge clk) corr <= 1'b1;
		pulse(4'hF, 4'h1);
		wr(`OFF_ENV_THREE, 32'h000F0000);
		pulse(4'hF, 4'hF);
		@(posedge clk) corr <= 1'b0;
		wr(`OFF_ENV_THREE, 32'h00004000);
		pulse(4'hF, 4'h7);
		@(posedge clk) busy_n <= 1'b0;
		pulse(4'hF, 4'hF);
		wr(`OFF_ENV_THREE, 32'h00008000);
		cnt = 0;
		repeat (8) begin
			@(posedge clk);
			#1 cnt += en_w[3];
		end
		chk("half clock ticks", 32'h4, 32'(cnt));
		wr(`OFF_ENV_THREE, 32'h0);
		p = '0;
		p[0] = 28'h14;
		ld(p, 1'b1);
		wr(`OFF_CMP1_VALUE, 32'hA);
		wr(`OFF_CMP2_VALUE, 32'h1E);
		wr(`OFF_ENV_FIVE, 32'h0);
		wr(`OFF_ENV_FOUR, 32'h00001818);
		rd(`OFF_STATUS, d);
		chk("positive limit", 32'h1, {31'h0, psl});
		chk("negative limit", 32'h1, {31'h0, nsl});
		for (k = 0; k < 3; k++) begin
			p = '0;
			p[3] = idr[k] ? 28'h2 : 28'h4;
			ld(p, idr[k]);
			wr(`OFF_CMP4_VALUE, 32'h3);
			wr(`OFF_ENV_FOUR, {2'h0, im[k], 26'h0} | 32'h03000000);
			pulse(4'h8, 4'h8);
			cnt = 0;
			repeat (6) begin
				@(posedge clk);
				#1 cnt += index_w;
			end
			chk("index pulses", ie[k], 32'(cnt));
		end
		p = '0;
		p[0] = 28'h7;
		ld(p, 1'b1);
		wr(`OFF_ENV_FOUR, 32'h0);
		wr(`OFF_IRQ_REQUEST, 32'h1000);
		wr(`OFF_CMP5_PRE, 32'h32);
		wr(`OFF_CMP5_VALUE, 32'h8);
		wr(`OFF_ENV_FIVE, 32'h48);
		pulse(4'h1, 4'h1);
		cnt = 0;
		lows = 0;
		repeat (6) begin
			@(posedge clk);
			#1 cnt += stop_now;
			lows += !int_n;
		end
		chk("stop pulses", 32'h1, 32'(cnt));
		chk("int_n low seen", 32'h1, {31'h0, lows != 0});
		rd(`OFF_CMP5_VALUE, d);
		chk("cmp5 reload", 32'h32, d);
		for (k = 2; k < 4; k++) begin
			p = '0;
			p[0] = 28'h7;
			ld(p, 1'b1);
			wr(`OFF_CMP1_VALUE, 32'h8);
			wr(`OFF_ENV_FOUR, (32'(k) << 5) | 32'h4);
			pulse(4'h1, 4'h1);
			cnt = 0;
			lows = 0;
			repeat (4) begin
				@(posedge clk);
				#1 cnt += decel;
				lows += reload;
			end
			chk("decel pulses", (k == 2) ? 32'h1 : 32'h0, 32'(cnt));
			chk("reload pulses", (k == 3) ? 32'h1 : 32'h0, 32'(lows));
		end
		@(posedge clk) rst_n <= 1'b0;
		@(posedge clk);
		#1 chk("rdata in reset", 32'h0, rdata);
		@(posedge clk) rst_n <= 1'b1;
		rd(`OFF_ENV_FOUR, d);
		chk("env4 after reset", 32'h0, d);
		give_verdict();
	end
endmodule : axis_cmp_block_tb_top

`default_nettype wire
